// ---- rtl/dcr_reg_bank.sv ----
// Control register bank of a single-channel voltage-output converter.
// Assumes the serial port delivers one-cycle write strobes and a read address
// already in the i_clk_sys domain.
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1 - Power-down bit 8 high turns the internal reference off.
// RQ2 - Power-down bit 0 high powers the output down into a 1k ground load.
// RQ3 - Gain bit 8 high halves the reference internally.
// RQ4 - Gain bit 0 picks buffer gain two or one; resets to two.
// RQ5 - In synchronous mode writing trigger bit 4 loads stored code to output.
// RQ6 - Writing key 1010 to trigger bits 3-0 restores every register's default.
// RQ7 - Output code is sixteen bits, unsigned straight binary, MSB aligned.
// RQ8 - Narrower variants keep the code in upper bits, low bits zero.
// RQ9 - Code resets to 0000h in zero-scale variant, 8000h in midscale.
// RQ10 - Sync enable set waits for trigger; clear updates output on each write.
// RQ11 - Command nibble 2,3,4,5,8 selects sync, power, gain, trigger, code.
// RQ12 - All registers read back except the reset key field.
// RQ13 - Other key patterns do nothing; a trigger in immediate mode adds nothing.
module dcr_reg_bank #(
    parameter int   RESOLUTION = dcr_pkg::RES_16,  // 16, 14 or 12 bits
    parameter bit   MIDSCALE   = 1'b0              // Power-on code at midscale
) (
    input  wire logic        i_clk_sys,     // System clock, 250 MHz
    input  wire logic        i_reset,       // Synchronous reset, active high
    input  wire logic        i_wr_en,       // Write strobe, one cycle
    input  wire logic [3:0]  i_wr_addr,     // Write command nibble
    input  wire logic [15:0] i_wr_data,     // Write data word
    input  wire logic [3:0]  i_rd_addr,     // Read command nibble
    output logic      [15:0] o_rd_data,     // Read data, registered
    output logic             o_rd_hit,      // Read address is mapped
    output logic             o_reference_disable, // Internal reference off
    output logic             o_output_power_down, // Output tied to ground
    output logic             o_ref_half,    // Reference divided by two
    output logic             o_buffer_double, // Buffer gain of two
    output logic             o_sync_mode,   // Synchronous update active
    output logic      [15:0] o_active_code  // Code driving the converter
);
    import dcr_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] align_code(input logic [15:0] d);
        logic [15:0] mask;
        mask = 16'hffff << (RES_16 - RESOLUTION);
        return d & mask; // [RQ7] [RQ8]
    endfunction

    // Write decode shared by every register strobe
    function automatic logic wr_hit(input logic en, input logic [3:0] addr, input logic [3:0] target);
        return en && (addr == target); // [RQ11]
    endfunction

    // Read decode; unmapped nibbles answer with zero and no hit
    function automatic logic is_mapped(input logic [3:0] addr);
        logic hit;
        case (addr) // [RQ11]
            ADDR_SYNC,
            ADDR_PWR_DOWN,
            ADDR_GAIN,
            ADDR_TRIGGER,
            ADDR_CODE: hit = 1'b1;
            default:   hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ==========================================================
    // Power-on values
    // Narrow variants mask the power-on code as well
    localparam logic [15:0] RST_CODE = MIDSCALE ? RST_CODE_MID : RST_CODE_ZERO;

    // ==========================================================
    // Register state
    logic [15:0] sync_r;
    logic [15:0] power_down_config_r;
    logic [15:0] gain_control_r;
    logic [15:0] load_and_reset_trigger_r;
    logic [15:0] output_code_r;
    logic [15:0] active_r;

    logic [15:0] active_nxt;
    logic [15:0] rd_nxt;
    logic        rd_hit_nxt;

    logic        soft_rst;
    logic        clear_all;
    logic        load_req;
    logic        wr_sync;
    logic        wr_pwr;
    logic        wr_gain;
    logic        wr_trig;
    logic        wr_code;

    // ==========================================================
    // Write decode
    // Unmapped nibbles match nothing and are dropped
    assign wr_sync   = wr_hit(i_wr_en, i_wr_addr, ADDR_SYNC);
    assign wr_pwr    = wr_hit(i_wr_en, i_wr_addr, ADDR_PWR_DOWN);
    assign wr_gain   = wr_hit(i_wr_en, i_wr_addr, ADDR_GAIN);
    assign wr_trig   = wr_hit(i_wr_en, i_wr_addr, ADDR_TRIGGER);
    assign wr_code   = wr_hit(i_wr_en, i_wr_addr, ADDR_CODE);

    // Only the exact key resets; any other pattern is inert
    assign soft_rst  = wr_trig && (i_wr_data[KEY_MSB:0] == RESET_KEY); // [RQ6] [RQ13]
    assign clear_all = i_reset || soft_rst; // [RQ6]
    // Key beats a load bit in the same word; no load in immediate mode
    assign load_req  = wr_trig && !soft_rst && i_wr_data[BIT_LOAD] && sync_r[BIT_SYNC_EN]; // [RQ5] [RQ13]

    // ==========================================================
    // Update mode register
    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            sync_r <= RST_SYNC;
        end else if (wr_sync) begin
            sync_r <= i_wr_data; // [RQ10]
        end
    end

    // ==========================================================
    // Power-down register
    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            power_down_config_r <= RST_PWR_DOWN;
        end else if (wr_pwr) begin
            power_down_config_r <= i_wr_data; // [RQ1] [RQ2]
        end
    end

    // ==========================================================
    // Gain register
    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            gain_control_r <= RST_GAIN; // [RQ4]
        end else if (wr_gain) begin
            gain_control_r <= i_wr_data; // [RQ3]
        end
    end

    // ==========================================================
    // Trigger register
    // Load bit kept for readback; key never stored
    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            load_and_reset_trigger_r <= RST_TRIGGER;
        end else if (wr_trig) begin
            load_and_reset_trigger_r <= {i_wr_data[15:KEY_MSB+1], 4'h0}; // [RQ12]
        end
    end

    // ==========================================================
    // Stored code
    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            output_code_r <= align_code(RST_CODE); // [RQ9]
        end else if (wr_code) begin
            output_code_r <= align_code(i_wr_data); // [RQ7]
        end
    end

    // ==========================================================
    // Converter output latch
    // Output follows each write in immediate mode, else waits for a load
    always_comb begin
        active_nxt = active_r;
        if (wr_code && !sync_r[BIT_SYNC_EN]) begin
            active_nxt = align_code(i_wr_data); // [RQ10]
        end else if (load_req) begin
            active_nxt = output_code_r; // [RQ5]
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (clear_all) begin
            active_r <= align_code(RST_CODE); // [RQ9]
        end else begin
            active_r <= active_nxt;
        end
    end

    // ==========================================================
    // Readback select
    always_comb begin
        rd_nxt     = 16'h0000;
        rd_hit_nxt = is_mapped(i_rd_addr); // [RQ11]
        case (i_rd_addr)
            ADDR_SYNC:     rd_nxt = sync_r;
            ADDR_PWR_DOWN: rd_nxt = power_down_config_r;
            ADDR_GAIN:     rd_nxt = gain_control_r;
            ADDR_TRIGGER:  rd_nxt = load_and_reset_trigger_r; // [RQ12]
            ADDR_CODE:     rd_nxt = output_code_r;
            default: ;
        endcase
    end

    // ==========================================================
    // Readback registers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rd_data <= 16'h0000;
        end else begin
            o_rd_data <= rd_nxt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rd_hit <= 1'b0;
        end else begin
            o_rd_hit <= rd_hit_nxt;
        end
    end

    // ==========================================================
    // Analog controls
    // Straight from register bits, so a write acts on the next cycle
    assign o_reference_disable = power_down_config_r[BIT_REF_DIS]; // [RQ1]
    assign o_output_power_down = power_down_config_r[BIT_OUT_PD];  // [RQ2]
    assign o_ref_half          = gain_control_r[BIT_REF_HALF];     // [RQ3]
    assign o_buffer_double     = gain_control_r[BIT_BUF_DBL];      // [RQ4]
    assign o_sync_mode         = sync_r[BIT_SYNC_EN];              // [RQ10]
    assign o_active_code       = active_r;
endmodule

`default_nettype wire

// ---- rtl/dcr_pkg.sv ----
// Constants for the converter control register bank.
// Assumes a serial front end that decodes the command nibble and data word.
`default_nettype none
package dcr_pkg;
    // ==========================================================
    // Register command codes (bits 19-16 of a frame)
    localparam logic [3:0]  ADDR_SYNC     = 4'h2;
    localparam logic [3:0]  ADDR_PWR_DOWN = 4'h3;
    localparam logic [3:0]  ADDR_GAIN     = 4'h4;
    localparam logic [3:0]  ADDR_TRIGGER  = 4'h5;
    localparam logic [3:0]  ADDR_CODE     = 4'h8;
    // ==========================================================
    // Field positions
    localparam int          BIT_SYNC_EN   = 0;
    localparam int          BIT_REF_DIS   = 8;
    localparam int          BIT_OUT_PD    = 0;
    localparam int          BIT_REF_HALF  = 8;
    localparam int          BIT_BUF_DBL   = 0;
    localparam int          BIT_LOAD      = 4;
    localparam int          KEY_MSB       = 3;
    localparam logic [3:0]  RESET_KEY     = 4'ha;
    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_SYNC      = 16'h0000;
    localparam logic [15:0] RST_PWR_DOWN  = 16'h0000;
    localparam logic [15:0] RST_GAIN      = 16'h0001;
    localparam logic [15:0] RST_TRIGGER   = 16'h0000;
    localparam logic [15:0] RST_CODE_ZERO = 16'h0000;
    localparam logic [15:0] RST_CODE_MID  = 16'h8000;
    // ==========================================================
    // Resolution variants
    localparam int          RES_16        = 16;
    localparam int          RES_14        = 14;
    localparam int          RES_12        = 12;
endpackage

`default_nettype wire

// ---- tb/dcr_host.sv ----
// Host model: drives register writes and reads at falling edges.
// Assumes the bank samples on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dcr_host (
    input  wire logic        i_clk, // Bank clock
    output logic             o_en,  // Write strobe
    output logic      [3:0]  o_wa,  // Write nibble
    output logic      [15:0] o_wd,  // Write word
    output logic      [3:0]  o_ra   // Read nibble
);
    initial {o_en, o_wa, o_wd, o_ra} = '0;
    // Strobe stays up so calls may follow back to back
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_en <= 1'b1;
        o_wa <= a;
        o_wd <= d;
    endtask
    // Idle word toggles so a stale value never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge i_clk);
            o_en <= 1'b0;
            o_wd <= ~o_wd;
        end
    endtask
    task automatic rd(input logic [3:0] a);
        @(negedge i_clk);
        o_ra <= a;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ---- tb/dcr_reg_bank_monitor.sv ----
// Checker of the register bank, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dcr_reg_bank_monitor #(parameter int RESOLUTION = 16, parameter bit MIDSCALE = 1'b0) (
    input wire logic        i_clk_sys, i_reset, i_wr_en, o_rd_hit, o_sync_mode, // Clock, control
    input wire logic        o_reference_disable, o_output_power_down, o_ref_half, o_buffer_double, // Analog
    input wire logic [3:0]  i_wr_addr, i_rd_addr, // Nibbles
    input wire logic [15:0] i_wr_data, o_rd_data, o_active_code // Words
);
    localparam logic [15:0] RC = MIDSCALE ? 16'h8000 : 16'h0000;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    wire logic w3 = i_wr_en && i_wr_addr == 4'h3;
    wire logic w4 = i_wr_en && i_wr_addr == 4'h4;
    wire logic w5 = i_wr_en && i_wr_addr == 4'h5;
    wire logic ky = w5 && i_wr_data[3:0] == 4'ha;
    chk_power_bits: assert property (
        w3 |=> {o_reference_disable, o_output_power_down} == {$past(i_wr_data[8]), $past(i_wr_data[0])})
        else $error("power bits");
    chk_gain_bits: assert property (
        w4 |=> {o_ref_half, o_buffer_double} == {$past(i_wr_data[8]), $past(i_wr_data[0])}) else $error("gain");
    chk_reset_vals: assert property (
        $fell(i_reset) |-> o_buffer_double && o_active_code == RC) else $error("reset values");
    chk_imm_code: assert property (
        i_wr_en && i_wr_addr == 4'h8 && !o_sync_mode
        |=> o_active_code == ($past(i_wr_data) & (16'hffff << (16 - RESOLUTION)))) else $error("code");
    chk_sync_hold: assert property (o_sync_mode && !w5 |=> $stable(o_active_code)) else $error("hold");
    chk_soft_rst: assert property (
        ky |=> !o_sync_mode && o_buffer_double && !o_ref_half && o_active_code == RC) else $error("soft reset");
    chk_rd_hit: assert property (
        1'b1 |=> o_rd_hit == ($past(i_rd_addr) inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8})) else $error("hit");
    chk_key_hidden: assert property (
        o_rd_hit && $past(i_rd_addr) == 4'h5 |-> o_rd_data[3:0] == 4'h0) else $error("key read");
    chk_bad_key: assert property (
        w5 && !ky && !(i_wr_data[4] && o_sync_mode) |=> $stable(o_active_code)) else $error("bad key");
    cover property (ky);
    cover property (w5 && i_wr_data[4] && o_sync_mode);
    cover property ($rose(o_output_power_down));
endmodule
bind dcr_reg_bank dcr_reg_bank_monitor #(.RESOLUTION(RESOLUTION), .MIDSCALE(MIDSCALE)) u_mon (.*);
`default_nettype wire

// ---- tb/tb_dcr_reg_bank.sv ----
// Random and corner-case bench for the register bank.
// Assumes a 14-bit midscale build driven by the host model.
`timescale 1ns/1ps
`default_nettype none
module tb_dcr_reg_bank;
    localparam int RES = 14;
    localparam logic [19:0] CQ [6] = '{20'h20001, 20'h8abcd, 20'h50015, 20'h81237, 20'h5001a, 20'h50006};
    logic clk = 1'b0, rst = 1'b1, en, hit, rdis, pd, half, dbl, sm;
    logic [3:0] wa, ra;
    logic [15:0] wd, rdd, code, act, e [16];
    int errors = 0, n_tests = 0;
    always #2 clk = ~clk;
    dcr_host HOST (.i_clk(clk), .o_en(en), .o_wa(wa), .o_wd(wd), .o_ra(ra));
    dcr_reg_bank #(.RESOLUTION(RES), .MIDSCALE(1'b1)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_wr_en(en),
        .i_wr_addr(wa), .i_wr_data(wd), .i_rd_addr(ra), .o_rd_data(rdd), .o_rd_hit(hit),
        .o_reference_disable(rdis), .o_output_power_down(pd), .o_ref_half(half),
        .o_buffer_double(dbl), .o_sync_mode(sm), .o_active_code(code));
    function automatic logic [15:0] exp_code(input logic [15:0] d);
        return d & (16'hffff << (16 - RES));
    endfunction
    function automatic logic mapped(input logic [3:0] a);
        return a inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
    endfunction
    task automatic cmp(input string s, input logic [15:0] x, y);
        n_tests++;
        if (x !== y) begin
            errors++;
            $display("wrong value %s exp %h got %h", s, x, y);
        end
    endtask
    task automatic dflt();
        foreach (e[a]) e[a] = '0;
        e[4] = 16'h0001;
        e[8] = 16'h8000;
        act = e[8];
    endtask
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        HOST.wr(a, d);
        if (a == 4'h8) d = exp_code(d);
        if (a == 4'h5 && d[3:0] == 4'ha) dflt();
        else if (mapped(a)) e[a] = a == 4'h5 ? d & 16'hfff0 : d;
        if (a == 4'h8 && !e[2][0] || a == 4'h5 && d[4] && e[2][0]) act = e[8];
    endtask
    task automatic chkall();
        HOST.idle(1);
        foreach (e[a]) begin
            HOST.rd(4'(a));
            cmp("read", e[a], rdd);
            cmp("hit", 16'(mapped(4'(a))), 16'(hit));
        end
        cmp("ctl", 16'({e[3][8], e[3][0], e[4][8], e[4][0], e[2][0]}), 16'({rdis, pd, half, dbl, sm}));
        cmp("code", act, code);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #80000;
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'haca1));
        dflt();
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chkall();
        $display("test reset done");
        foreach (CQ[i]) begin
            put(CQ[i][19:16], CQ[i][15:0]);
            chkall();
        end
        $display("test corner done");
        repeat (40) begin
            put(4'($urandom_range(2, 9)), 16'($urandom));
            put(4'($urandom_range(2, 9)), 16'($urandom));
            chkall();
        end
        $display("test random done");
        // Reset again over random state; every default must return
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        dflt();
        chkall();
        $display("test mid reset done");
        conclude();
    end
endmodule
`default_nettype wire
